/* hcm_pkg.sv */
// Purpose: shared constants and carriers for the host register and maintenance port
// Assumes: 250 MHz system clock, eight byte registers in flip-flops
// Notes: maintenance bit positions are given within the odd byte (register bit minus 8)
package hcm_pkg;
  localparam int CLOCK_NS = 4;
  localparam int STEP_PULSE_NS = 60;
  // least time, rounded up to whole cycles
  localparam int STEP_PULSE_CYCLES = (STEP_PULSE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam logic [3:0] TICK_LAST = 4'(STEP_PULSE_CYCLES - 1);
  localparam logic [2:0] STEP_PULSES = 3'h5;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam logic [2:0] MAINT_BYTE = 3'h1;
  localparam logic [2:0] PC_WORD = 3'h4;
  localparam logic [2:0] MICROWORD_WORD = 3'h6;
  localparam logic [7:0] MAINT_RESET = 8'h00;

  localparam int M_STEP = 0;
  localparam int M_INJECT = 1;
  localparam int M_CS_ACCESS = 2;
  localparam int M_LOOPBACK = 3;
  localparam int M_CS_WRITE = 5;
  localparam int M_MASTER_CLEAR = 6;
  localparam int M_RUN = 7;

  typedef struct packed {
    logic sel;
    logic write;
    logic byte_mode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } hcm_host_req_s;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] rdata;
  } hcm_host_rsp_s;

  typedef struct packed {
    logic we;
    logic [2:0] addr;
    logic [7:0] wdata;
  } hcm_mp_req_s;

  typedef struct packed {
    logic mp_tick;
    logic run;
    logic step_active;
    logic inject;
    logic cs_access;
    logic cs_we;
    logic master_clear;
    logic [DATA_W-1:0] cs_addr;
    logic [DATA_W-1:0] cs_wdata;
  } hcm_maint_s;
endpackage : hcm_pkg

/* hcm_port.sv */
// Purpose: host byte registers, address and vector switches, maintenance flip-flops
// Assumes: one 250 MHz clock, synchronous active-high reset, switches and init are pins
// Notes: the host reads the shared RAM, or pc and control store for words 4 and 6 while the access bit is set; the microprocessor never writes the flip-flops
`timescale 1ns/1ps
// Operation
// - eight byte registers at octal 0-7, also reachable as words at even bytes
// - OUT is microprocessor to host, IN is host to microprocessor
// - byte 1 is maintenance; other seven bytes are free for microcode
// - maintenance byte lives in shared RAM, host writes mirrored in flip-flops
// - every defined maintenance bit is host readable and writable
// - step bit runs one instruction cycle of five 60 ns pulses
// - inject bit makes bytes 6-7 the next microword on a step
// - control store access bit sources word 4 from control store pc
// - host loads word 6 then sets write bit; reads control store via word 6
// - loopback bit held in a flip-flop driving a connector pin
// - address bits 3-12 match switches: open means 1, closed means 0
// - vector bits 3-8 from switches: open gives 0, closed gives 1
// - vector bit 2 from logic: input interrupts end 0, output end 4
// - address bits 0-2 select one of eight byte registers
// - write bit with access bit stores word 6 at address in word 4
// - run bit gates clock; bus init or master clear clears it
module hcm_port (
  input wire logic clock,
  input wire logic reset,
  input hcm_pkg::hcm_host_req_s host_req,
  output hcm_pkg::hcm_host_rsp_s host_rsp,
  input hcm_pkg::hcm_mp_req_s mp_req,
  output logic [7:0] mp_rdata,
  input wire logic [9:0] addr_switch_closed,
  input wire logic [5:0] vector_switch_closed,
  input wire logic bus_init,
  input wire logic vector_is_output,
  output logic [8:0] vector,
  input wire logic [hcm_pkg::DATA_W-1:0] cs_pc,
  input wire logic [hcm_pkg::DATA_W-1:0] cs_rdata,
  output hcm_pkg::hcm_maint_s maint_out,
  output logic serial_loopback_flag
);
  import hcm_pkg::*;

  typedef struct packed {
    logic [9:0] asw1;
    logic [9:0] asw2;
    logic [5:0] vsw1;
    logic [5:0] vsw2;
    logic init1;
    logic init2;
    logic [7:0][7:0] ram;
    logic [7:0] maint;
    logic step_busy;
    logic [2:0] step_left;
    logic [3:0] tick_cnt;
    logic mp_tick;
    logic cs_we;
    logic ack;
    logic [DATA_W-1:0] rdata;
    logic [7:0] mp_rdata;
    logic [8:0] vector;
  } hcm_state_s;

  hcm_state_s s;
  hcm_state_s next_s;
  logic hit;
  logic [2:0] idx;
  logic [7:0] new_maint;
  logic maint_wr;

  function automatic logic [DATA_W-1:0] word_at(input logic [7:0][7:0] ram, input logic [2:0] i);
    word_at = {ram[{i[2:1], 1'b1}], ram[{i[2:1], 1'b0}]};
  endfunction : word_at

  always_comb
  begin
    next_s = s;
    // pins pass two flip-flops before use
    next_s.asw1 = addr_switch_closed;
    next_s.asw2 = s.asw1;
    next_s.vsw1 = vector_switch_closed;
    next_s.vsw2 = s.vsw1;
    next_s.init1 = bus_init;
    next_s.init2 = s.init1;
    next_s.ack = 1'b0;
    next_s.mp_tick = 1'b0;
    next_s.cs_we = 1'b0;
    idx = host_req.addr[2:0];
    new_maint = s.maint;
    maint_wr = 1'b0;
    hit = host_req.sel && (&host_req.addr[ADDR_W-1:13]) && (host_req.addr[12:3] == ~s.asw2);
    // microprocessor side writes only the RAM
    if (mp_req.we)
    begin
      next_s.ram[mp_req.addr] = mp_req.wdata;
    end
    next_s.mp_rdata = s.ram[mp_req.addr];
    if (hit)
    begin
      next_s.ack = 1'b1;
      if (host_req.write)
      begin
        if (host_req.byte_mode)
        begin
          next_s.ram[idx] = idx[0] ? host_req.wdata[15:8] : host_req.wdata[7:0];
          maint_wr = (idx == MAINT_BYTE);
        end
        else
        begin
          next_s.ram[{idx[2:1], 1'b0}] = host_req.wdata[7:0];
          next_s.ram[{idx[2:1], 1'b1}] = host_req.wdata[15:8];
          maint_wr = (idx[2:1] == MAINT_BYTE[2:1]);
        end
        new_maint = host_req.wdata[15:8];
      end
      else
      begin
        // pc and control store replace words 4 and 6
        if (s.maint[M_CS_ACCESS] && idx[2:1] == PC_WORD[2:1])
          next_s.rdata = cs_pc;
        else if (s.maint[M_CS_ACCESS] && idx[2:1] == MICROWORD_WORD[2:1])
          next_s.rdata = cs_rdata;
        else
          next_s.rdata = word_at(s.ram, idx);
      end
    end
    if (maint_wr)
    begin
      next_s.maint = new_maint;
      if (new_maint[M_STEP] && !s.maint[M_STEP] && !s.step_busy)
      begin
        next_s.step_busy = 1'b1;
        next_s.step_left = STEP_PULSES;
        next_s.tick_cnt = '0;
      end
      if (new_maint[M_CS_WRITE] && !s.maint[M_CS_WRITE] && new_maint[M_CS_ACCESS])
        next_s.cs_we = 1'b1;
    end
    // init or master clear stops clock
    if (s.init2 || next_s.maint[M_MASTER_CLEAR])
      next_s.maint[M_RUN] = 1'b0;
    // 60 ns pulses; five while stepping
    if (s.maint[M_RUN] || s.step_busy)
    begin
      if (s.tick_cnt == TICK_LAST)
      begin
        next_s.tick_cnt = '0;
        next_s.mp_tick = 1'b1;
        if (s.step_busy && !s.maint[M_RUN])
        begin
          next_s.step_left = s.step_left - 3'h1;
          next_s.step_busy = (s.step_left != 3'h1);
        end
      end
      else
      begin
        next_s.tick_cnt = s.tick_cnt + 4'h1;
      end
    end
    // running clock makes a step meaningless, so drop it
    if (s.maint[M_RUN] && s.step_busy)
      next_s.step_busy = 1'b0;
    // vector bit 2 from interrupt kind
    next_s.vector = {s.vsw2, vector_is_output, 2'b00};
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s <= '0;
      s.maint <= MAINT_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign host_rsp.ack = s.ack;
  assign host_rsp.rdata = s.rdata;
  // out data reaches host via ram; in data read here
  assign mp_rdata = s.mp_rdata;
  assign vector = s.vector;
  assign maint_out.mp_tick = s.mp_tick;
  assign maint_out.run = s.maint[M_RUN];
  assign maint_out.step_active = s.step_busy;
  // inject level with microword in bytes 6-7
  assign maint_out.inject = s.maint[M_INJECT];
  assign maint_out.cs_access = s.maint[M_CS_ACCESS];
  assign maint_out.cs_we = s.cs_we;
  assign maint_out.master_clear = s.maint[M_MASTER_CLEAR];
  assign maint_out.cs_addr = word_at(s.ram, PC_WORD);
  assign maint_out.cs_wdata = word_at(s.ram, MICROWORD_WORD);
  // loopback flag straight from its flip-flop
  assign serial_loopback_flag = s.maint[M_LOOPBACK];

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  logic [2:0] step_ticks;
  always_ff @(posedge clock)
  begin
    // the last pulse lands as busy falls, so keep counting while it stands
    if (reset || (!s.step_busy && !s.mp_tick))
      step_ticks <= '0;
    else if (s.mp_tick)
      step_ticks <= step_ticks + 3'h1;
  end

  a_ack_on_hit: assert property (hit |=> host_rsp.ack)
    else $error("matched access not acknowledged");
  a_switch_miss: assert property (host_req.addr[12:3] != ~s.asw2 |=> !host_rsp.ack)
    else $error("mismatched address acknowledged");
  a_word_pair: assert property (hit && host_req.write && !host_req.byte_mode && !mp_req.we
    |=> word_at(s.ram, $past(idx)) == $past(host_req.wdata))
    else $error("word write did not fill both bytes");
  a_maint_mirror: assert property (maint_wr |=> s.maint[6:0] == s.ram[MAINT_BYTE][6:0])
    else $error("maintenance flip-flops differ from written byte");
  a_mp_no_touch: assert property (!maint_wr |=> s.maint[6:0] == $past(s.maint[6:0]))
    else $error("maintenance flip-flops changed without host write");
  a_step_five: assert property ($fell(s.step_busy) && !s.maint[M_RUN] |=> step_ticks == STEP_PULSES)
    else $error("step did not give five pulses");
  a_step_once: assert property ($fell(s.step_busy) && s.maint[M_STEP] |=> !s.step_busy)
    else $error("held step bit retriggered");
  a_run_cleared: assert property (s.init2 |=> !maint_out.run)
    else $error("run not cleared by bus init");
  a_clear_stops: assert property (maint_out.master_clear |-> !maint_out.run)
    else $error("run set while master clear held");
  a_vector_form: assert property (##1 vector == {$past(s.vsw2), $past(vector_is_output), 2'b00})
    else $error("vector not built from switches and kind");
  a_pc_source: assert property (hit && !host_req.write && s.maint[M_CS_ACCESS] && idx[2:1] == 2'h2
    |=> host_rsp.rdata == $past(cs_pc))
    else $error("word 4 not sourced from control store pc");
  a_cs_write: assert property (maint_out.cs_we |-> s.maint[M_CS_ACCESS] && s.maint[M_CS_WRITE])
    else $error("control store write without access bit");

  c_step_done: cover property (s.step_busy ##[1:200] !s.step_busy);
  c_cs_write: cover property (maint_out.cs_we);
  c_loopback: cover property (maint_wr ##1 serial_loopback_flag);
endmodule : hcm_port

/* hcm_host_model.sv */
// Purpose: host processor model issuing register bus cycles
// Assumes: one access at a time, sel high for one cycle
// Notes: released lines show inverted values; gives up after 3 cycles
`timescale 1ns/1ps
module hcm_host_model (
  input wire logic clock,
  output hcm_pkg::hcm_host_req_s req,
  input hcm_pkg::hcm_host_rsp_s rsp
);
  import hcm_pkg::*;
  initial req = '0;
  task automatic access(input logic w, input logic b, input logic [17:0] a,
                        input logic [15:0] d, output logic [15:0] q, output logic got);
    got = 1'h0;
    q = 16'h0;
    @(negedge clock);
    req <= '{1'h1, w, b, a, d};
    // sel stands over one taking edge only; ack stands one cycle, so look mid-cycle
    for (int i = 0; i < 3 && !got; i++)
    begin
      @(negedge clock);
      // stale address and data are not left on the bus
      if (i == 0)
        req <= '{1'h0, ~w, ~b, ~a, ~d};
      got = (rsp.ack === 1'h1);
      q = rsp.rdata;
    end
  endtask : access
endmodule : hcm_host_model

/* host_csr_maintenance_port_test.sv */
// Purpose: self-checking bench for the host register and maintenance port
// Assumes: block base at octal 760200, vector switches give 360
// Notes: inputs change at the falling edge
`timescale 1ns/1ps
module host_csr_maintenance_port_test;
  import hcm_pkg::*;
  localparam logic [17:0] BASE = 18'h3E080;
  logic clock, reset, bus_init, vector_is_output, serial_loopback_flag, got;
  logic [9:0] addr_switch_closed;
  logic [5:0] vector_switch_closed;
  hcm_host_req_s host_req;
  hcm_host_rsp_s host_rsp;
  hcm_mp_req_s mp_req;
  hcm_maint_s maint_out;
  logic [7:0] mp_rdata;
  logic [8:0] vector;
  logic [15:0] cs_pc, cs_rdata, q;
  int n_errors = 0, n_checks = 0, cycles = 0, ticks = 0;
  typedef struct packed {logic [2:0] off; logic byt; logic [15:0] d, e;} hcm_row_s;
  hcm_row_s rows [5] = '{'{3'h0, 1'h0, 16'h1234, 16'h1234}, '{3'h3, 1'h1, 16'hAB00, 16'hAB00},
    '{3'h2, 1'h1, 16'h00CD, 16'hABCD}, '{3'h4, 1'h0, 16'hBEEF, 16'hBEEF},
    '{3'h7, 1'h0, 16'hF00D, 16'hF00D}};
  hcm_port i_hcm_port (.clock, .reset, .host_req, .host_rsp, .mp_req, .mp_rdata,
    .addr_switch_closed, .vector_switch_closed, .bus_init, .vector_is_output, .vector,
    .cs_pc, .cs_rdata, .maint_out, .serial_loopback_flag);
  hcm_host_model i_hcm_host_model (.clock, .req(host_req), .rsp(host_rsp));
  initial
  begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  // run is about 440 cycles; the ceiling leaves ample room
  always @(posedge clock)
  begin
    cycles++;
    if (maint_out.mp_tick === 1'h1) ticks++;
    if (cycles == 6000)
    begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic b, input logic [2:0] o, input logic [15:0] d);
    i_hcm_host_model.access(1'h1, b, BASE + 18'(o), d, q, got);
  endtask : wr
  task automatic rd(input logic [2:0] o);
    i_hcm_host_model.access(1'h0, 1'h0, BASE + 18'(o), 16'h0, q, got);
  endtask : rd
  task automatic maint(input logic [7:0] v);
    wr(1'h1, 3'h1, {v, 8'h00});
  endtask : maint
  task automatic step_count(input logic [7:0] v, input int e);
    ticks = 0;
    maint(v);
    repeat (90) @(negedge clock);
    chk("ticks", 16'(e), 16'(ticks));
    chk("step_active", 16'h0, 16'(maint_out.step_active));
  endtask : step_count
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  initial
  begin
    reset = 1'h1;
    bus_init = 1'h0;
    vector_is_output = 1'h0;
    mp_req = '0;
    addr_switch_closed = 10'h3EF;
    vector_switch_closed = 6'h1E;
    cs_pc = 16'h0123;
    cs_rdata = 16'h4567;
    repeat (6) @(negedge clock);
    reset = 1'h0;
    repeat (3) @(negedge clock);
    chk("maint_out", 16'h1, 16'(maint_out === '0));
    $display("reset test done");
    foreach (rows[i])
    begin
      wr(rows[i].byt, rows[i].off, rows[i].d);
      rd(rows[i].off);
      chk("ack", 16'h1, 16'(got));
      chk("word", rows[i].e, q);
    end
    chk("cs_addr", 16'hBEEF, maint_out.cs_addr);
    chk("cs_wdata", 16'hF00D, maint_out.cs_wdata);
    mp_req.addr = 3'h7;
    repeat (2) @(negedge clock);
    chk("mp_rdata", 16'h00F0, 16'(mp_rdata));
    $display("register rows done");
    i_hcm_host_model.access(1'h1, 1'h0, BASE ^ 18'h8, 16'hFFFF, q, got);
    chk("ack bit3", 16'h0, 16'(got));
    i_hcm_host_model.access(1'h1, 1'h0, BASE ^ 18'h20000, 16'hFFFF, q, got);
    chk("ack bit17", 16'h0, 16'(got));
    rd(3'h0);
    chk("untouched", 16'h1234, q);
    mp_req.addr = 3'h1;
    mp_req.wdata = 8'h55;
    mp_req.we = 1'h1;
    @(negedge clock);
    mp_req.we = 1'h0;
    rd(3'h0);
    chk("mp write ram", 16'h5534, q);
    chk("mp inject kept", 16'h1, 16'(maint_out.inject));
    chk("mp clear kept", 16'h0, 16'(maint_out.master_clear));
    chk("mp access kept", 16'h0, 16'(maint_out.cs_access));
    $display("decode test done");
    maint(8'h08);
    rd(3'h0);
    chk("maint read", 16'h0834, q);
    chk("loopback", 16'h1, 16'(serial_loopback_flag));
    maint(8'h04);
    rd(3'h4);
    chk("cs pc", 16'h0123, q);
    rd(3'h6);
    chk("cs read", 16'h4567, q);
    maint(8'h24);
    chk("cs_we", 16'h1, 16'(maint_out.cs_we));
    chk("cs_access", 16'h1, 16'(maint_out.cs_access));
    $display("maintenance test done");
    // run is left clear while stepping
    step_count(8'h03, 5);
    chk("inject", 16'h1, 16'(maint_out.inject));
    step_count(8'h03, 0);
    step_count(8'h00, 0);
    step_count(8'h01, 5);
    $display("step test done");
    maint(8'h80);
    chk("run", 16'h1, 16'(maint_out.run));
    bus_init = 1'h1;
    repeat (4) @(negedge clock);
    bus_init = 1'h0;
    chk("run init", 16'h0, 16'(maint_out.run));
    maint(8'h80);
    maint(8'hC0);
    repeat (2) @(negedge clock);
    chk("run clear", 16'h0, 16'(maint_out.run));
    chk("master_clear", 16'h1, 16'(maint_out.master_clear));
    maint(8'h00);
    $display("run test done");
    for (int k = 0; k < 2; k++)
    begin
      vector_is_output = k[0];
      repeat (2) @(negedge clock);
      chk("vector", {7'h0, 6'h1E, k[0], 2'h0}, 16'(vector));
    end
    $display("vector test done");
    stop_test();
  end
endmodule : host_csr_maintenance_port_test
